// [include/pmcd_map.svh]
// register offsets, field positions, reset values and timing counts of the power unit
`ifndef PMCD_MAP_SVH
`define PMCD_MAP_SVH
// the two unit registers sit at word index; the byte address is four times it
`define PMCD_IDX_POWER_CTRL 10'h087
`define PMCD_IDX_CORE_DIV 10'h097
`define PMCD_OFF_POWER_CTRL {`PMCD_IDX_POWER_CTRL, 2'b00}
`define PMCD_OFF_CORE_DIV {`PMCD_IDX_CORE_DIV, 2'b00}
`define PMCD_OFF_STATUS 12'h0a0
`define PMCD_OFF_CONFIG 12'h0a4
`define PMCD_BIT_HALT 0
`define PMCD_BIT_PDOWN 1
`define PMCD_BIT_FLAG_ZERO 2
`define PMCD_BIT_FLAG_ONE 3
`define PMCD_BIT_PON 4
`define PMCD_BIT_LOWSUP 5
`define PMCD_BIT_FESEL 6
`define PMCD_BIT_BAUD2 7
`define PMCD_POWER_CTRL_RST 8'h10
`define PMCD_CORE_DIV_RST 3'h0
`define PMCD_WAKE_CYCLES 32768
`define PMCD_RESET_CYCLES 24
`endif

// [include/pmcd_pkg.sv]
// types shared by the power unit files
`default_nettype none
package pmcd_pkg;
  typedef enum logic [1:0] {
    PMCD_RUN = 2'b00,
    PMCD_IDLE = 2'b01,
    PMCD_DOWN = 2'b10,
    PMCD_WARM = 2'b11
  } pmcd_state_t;
  // wake sources in one bundle
  typedef struct packed {
    logic irq0;
    logic irq1;
    logic timer_zero_count_pin;
    logic timer_one_count_pin;
    logic rxd;
    logic cap0;
    logic cap1;
    logic lowvolt;
  } pmcd_wake_t;
endpackage : pmcd_pkg
`default_nettype wire

// [hdl/pmcd_divider.sv]
// power-of-two clock enable divider for the core logic
`default_nettype none
module pmcd_divider
  import pmcd_pkg::*;
#(
  parameter int CODE_W = 3
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic run,
  input wire logic [CODE_W-1:0] code,
  output logic tick
);
  localparam int CNT_W = (1 << CODE_W) - 1;
  if (CODE_W < 1 || CODE_W > 4) begin : g_bad_code
    $error("pmcd_divider: CODE_W out of range");
  end
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] mask;
  // mask selects the low code bits of the counter
  always_comb begin
    mask = CNT_W'((1 << code) - 1);
  end
  // counter wraps at 2**code; tick on wrap, stopped when not running
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else begin
      tick <= ((cnt_r & mask) == mask);
      cnt_r <= ((cnt_r & mask) == mask) ? '0 : cnt_r + 1'b1;
    end
  end
endmodule : pmcd_divider
`default_nettype wire

// [hdl/pmcd_power_unit.sv]
// power control and clock divider unit with APB register access
`include "pmcd_map.svh"
`default_nettype none
module pmcd_power_unit
  import pmcd_pkg::*;
#(
  parameter int WAKE_CYCLES = `PMCD_WAKE_CYCLES,
  parameter int CODE_W = 3
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_on_event,
  input wire logic low_supply_detect,
  input wire pmcd_wake_t wake_pins,
  input wire logic irq_pending,
  input wire logic ext_reset_req,
  input wire logic [7:0] port_levels_in,
  output logic [7:0] port_levels_out,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic prog_counter_array_clk_en,
  output logic osc_run,
  output logic core_reset,
  output logic core_restart_zero,
  output logic baud_double,
  output logic frame_error_select,
  output logic addr_latch_strobe,
  output logic program_store_strobe
);
  localparam int WCNT_W = $clog2(WAKE_CYCLES + 1);
  localparam int RCNT_W = 5;
  localparam logic [RCNT_W-1:0] RESET_HOLD = RCNT_W'(`PMCD_RESET_CYCLES);
  if (WAKE_CYCLES < 1) begin : g_bad_wake
    $error("pmcd_power_unit: WAKE_CYCLES must be positive");
  end
  if (CODE_W != 3) begin : g_bad_code
    $error("pmcd_power_unit: only a 3-bit divider code is served");
  end

  logic cpu_halt_select_r;
  logic power_down_select_r;
  logic general_flag_zero_r;
  logic general_flag_one_r;
  logic power_on_flag_r;
  logic low_supply_flag_r;
  logic frame_error_select_r;
  logic baud_double_r;
  logic [CODE_W-1:0] core_divider_code_r;
  logic array_idle_run_r;
  pmcd_state_t state_r;
  pmcd_state_t state_nxt;
  logic [WCNT_W-1:0] wake_cnt_r;
  logic [RCNT_W-1:0] rst_cnt_r;
  logic div_tick;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic pctrl_wr;
  logic any_wake;
  logic reset_done;
  logic [7:0] pctrl_rd;

  // single-cycle access: ready in the access phase
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign addr_ok = (paddr == `PMCD_OFF_POWER_CTRL) || (paddr == `PMCD_OFF_CORE_DIV) ||
                   (paddr == `PMCD_OFF_STATUS) || (paddr == `PMCD_OFF_CONFIG);
  assign pctrl_wr = wr_en && (paddr == `PMCD_OFF_POWER_CTRL);
  assign any_wake = |wake_pins;
  assign reset_done = (rst_cnt_r == RESET_HOLD);

  // power_ctrl read image
  always_comb begin
    pctrl_rd = 8'h00;
    pctrl_rd[`PMCD_BIT_HALT] = cpu_halt_select_r;
    pctrl_rd[`PMCD_BIT_PDOWN] = power_down_select_r;
    pctrl_rd[`PMCD_BIT_FLAG_ZERO] = general_flag_zero_r;
    pctrl_rd[`PMCD_BIT_FLAG_ONE] = general_flag_one_r;
    pctrl_rd[`PMCD_BIT_PON] = power_on_flag_r;
    pctrl_rd[`PMCD_BIT_LOWSUP] = low_supply_flag_r;
    pctrl_rd[`PMCD_BIT_FESEL] = frame_error_select_r;
    pctrl_rd[`PMCD_BIT_BAUD2] = baud_double_r;
  end

  // apb answer; read data registered in setup so it stands in access
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_en) begin
        unique case (paddr)
          `PMCD_OFF_POWER_CTRL: prdata <= {24'h000000, pctrl_rd};
          `PMCD_OFF_CORE_DIV: prdata <= {29'h0, core_divider_code_r};
          `PMCD_OFF_STATUS: prdata <= {30'h0, state_r};
          `PMCD_OFF_CONFIG: prdata <= {31'h0, array_idle_run_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // plain software bits
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      general_flag_zero_r <= 1'b0;
      general_flag_one_r <= 1'b0;
      frame_error_select_r <= 1'b0;
      baud_double_r <= 1'b0;
      core_divider_code_r <= CODE_W'(`PMCD_CORE_DIV_RST);
      array_idle_run_r <= 1'b0;
    end else begin
      if (pctrl_wr) begin
        general_flag_zero_r <= pwdata[`PMCD_BIT_FLAG_ZERO];
        general_flag_one_r <= pwdata[`PMCD_BIT_FLAG_ONE];
        frame_error_select_r <= pwdata[`PMCD_BIT_FESEL];
        baud_double_r <= pwdata[`PMCD_BIT_BAUD2];
      end
      // divider may change at any time
      if (wr_en && paddr == `PMCD_OFF_CORE_DIV) begin
        core_divider_code_r <= pwdata[CODE_W-1:0];
      end
      if (wr_en && paddr == `PMCD_OFF_CONFIG) begin
        array_idle_run_r <= pwdata[0];
      end
    end
  end

  // sticky hardware flags: the set wins over a software clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      power_on_flag_r <= 1'b1;
      low_supply_flag_r <= 1'b0;
    end else begin
      if (power_on_event) begin
        power_on_flag_r <= 1'b1;
      end else if (pctrl_wr && !pwdata[`PMCD_BIT_PON]) begin
        power_on_flag_r <= 1'b0;
      end
      if (low_supply_detect) begin
        low_supply_flag_r <= 1'b1;
      end else if (pctrl_wr && !pwdata[`PMCD_BIT_LOWSUP]) begin
        low_supply_flag_r <= 1'b0;
      end
    end
  end

  // mode select bits; hardware clears them on wake
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cpu_halt_select_r <= 1'b0;
      power_down_select_r <= 1'b0;
    end else if (ext_reset_req && reset_done) begin
      cpu_halt_select_r <= 1'b0;
      power_down_select_r <= 1'b0;
    end else if (state_r == PMCD_IDLE && irq_pending) begin
      cpu_halt_select_r <= 1'b0;
    end else if (state_r == PMCD_DOWN && any_wake) begin
      power_down_select_r <= 1'b0;
      cpu_halt_select_r <= 1'b0;
    end else if (pctrl_wr) begin
      cpu_halt_select_r <= pwdata[`PMCD_BIT_HALT];
      power_down_select_r <= pwdata[`PMCD_BIT_PDOWN];
    end
  end

  // mode sequencer; power-down has priority over idle
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PMCD_RUN: begin
        if (pctrl_wr && pwdata[`PMCD_BIT_PDOWN]) begin
          state_nxt = PMCD_DOWN;
        end else if (pctrl_wr && pwdata[`PMCD_BIT_HALT]) begin
          state_nxt = PMCD_IDLE;
        end
      end
      PMCD_IDLE: begin
        if (irq_pending) begin
          state_nxt = PMCD_RUN;
        end
      end
      PMCD_DOWN: begin
        if (any_wake) begin
          state_nxt = PMCD_WARM;
        end
      end
      PMCD_WARM: begin
        if (wake_cnt_r == WCNT_W'(WAKE_CYCLES - 1)) begin
          state_nxt = PMCD_RUN;
        end
      end
    endcase
    if (ext_reset_req && reset_done) begin
      state_nxt = PMCD_RUN;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= PMCD_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // settle counter after pin wake; oscillator running, clocks blocked
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wake_cnt_r <= '0;
    end else if (state_r == PMCD_WARM) begin
      wake_cnt_r <= wake_cnt_r + 1'b1;
    end else begin
      wake_cnt_r <= '0;
    end
  end

  // reset pin must be held the minimum time while the oscillator runs
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_cnt_r <= '0;
    end else if (!ext_reset_req) begin
      rst_cnt_r <= '0;
    end else if (!reset_done) begin
      rst_cnt_r <= rst_cnt_r + 1'b1;
    end
  end

  pmcd_divider #(
    .CODE_W(CODE_W)
  ) u_div (
    .mclk(mclk),
    .rstn(rstn),
    .run(state_r != PMCD_DOWN),
    .code(core_divider_code_r),
    .tick(div_tick)
  );

  // clock enables and held pins, all registered
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cpu_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
      prog_counter_array_clk_en <= 1'b0;
      osc_run <= 1'b1;
      core_reset <= 1'b0;
      core_restart_zero <= 1'b0;
      baud_double <= 1'b0;
      frame_error_select <= 1'b0;
      addr_latch_strobe <= 1'b1;
      program_store_strobe <= 1'b1;
      port_levels_out <= 8'h00;
    end else begin
      // gating the cpu, and the array unless array_idle_run_r is set, keeps their state intact
      cpu_clk_en <= div_tick && state_nxt == PMCD_RUN;
      periph_clk_en <= div_tick && (state_nxt == PMCD_RUN || state_nxt == PMCD_IDLE);
      prog_counter_array_clk_en <= div_tick && (state_nxt == PMCD_RUN ||
                                   (state_nxt == PMCD_IDLE && array_idle_run_r));
      osc_run <= state_nxt != PMCD_DOWN;
      core_reset <= ext_reset_req && reset_done;
      core_restart_zero <= ext_reset_req && reset_done && state_r != PMCD_RUN;
      baud_double <= baud_double_r;
      frame_error_select <= frame_error_select_r;
      if (state_nxt == PMCD_IDLE) begin
        addr_latch_strobe <= 1'b1;
        program_store_strobe <= 1'b1;
      end else begin
        addr_latch_strobe <= 1'b0;
        program_store_strobe <= 1'b0;
      end
      if (state_r != PMCD_IDLE) begin
        port_levels_out <= port_levels_in;
      end
    end
  end

  // a completed reset pin overrides the mode write, so it is left out here
  a_pdown_priority: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == PMCD_RUN && pctrl_wr && pwdata[1] && !(ext_reset_req && reset_done))
    |=> state_r == PMCD_DOWN)
    else $error("power-down not entered");
  a_halt_enter: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == PMCD_RUN && pctrl_wr && pwdata[1:0] == 2'b01 && !(ext_reset_req && reset_done))
    |=> state_r == PMCD_IDLE ##1 (!cpu_clk_en || $past(irq_pending) || $past(ext_reset_req)))
    else $error("idle not entered");
  a_idle_wake: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == PMCD_IDLE && irq_pending) |=> !cpu_halt_select_r && state_r == PMCD_RUN)
    else $error("idle not ended by interrupt");
  a_osc_stop: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == PMCD_DOWN && !any_wake && !ext_reset_req) |=> !osc_run)
    else $error("oscillator runs in power-down");
  a_pon_sticky: assert property (@(posedge mclk) disable iff (!rstn)
    (power_on_flag_r && !pctrl_wr) |=> power_on_flag_r)
    else $error("power-on flag lost");
  a_low_set: assert property (@(posedge mclk) disable iff (!rstn)
    low_supply_detect |=> low_supply_flag_r)
    else $error("low supply flag not set");
  a_reset_hold: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(ext_reset_req) |-> !core_reset [*8])
    else $error("reset completed too early");
  a_idle_strobes: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == PMCD_IDLE) |-> addr_latch_strobe && program_store_strobe)
    else $error("strobes not high in idle");
  // the divider tick lags reset release by one edge, hence the past reset term
  a_div_zero: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == PMCD_RUN && core_divider_code_r == 3'h0 && $past(state_r) == PMCD_RUN
     && state_nxt == PMCD_RUN && $past(core_divider_code_r) == 3'h0 && $past(rstn))
    |=> cpu_clk_en)
    else $error("undivided clock not every cycle");
endmodule : pmcd_power_unit
`default_nettype wire

// [tb/pmcd_partner.sv]
// far-side model: interrupt sources, wake pins, reset pin and supply monitors
`default_nettype none
module pmcd_partner
  import pmcd_pkg::*;
(
  input wire logic mclk,
  output pmcd_wake_t wake_pins,
  output logic irq_pending,
  output logic ext_reset_req,
  output logic low_supply_detect,
  output logic power_on_event,
  output logic [7:0] port_levels_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // line map: 0-7 wake pins, 8 irq, 9 reset pin, 10 low supply, 11 power on
  logic [11:0] lines_r = 12'h000;
  assign wake_pins = pmcd_wake_t'(lines_r[7:0]);
  assign {power_on_event, low_supply_detect, ext_reset_req, irq_pending} = lines_r[11:8];
  // port pins move every cycle so a frozen copy is told apart from a live one
  logic [7:0] port_r = 8'h5a;
  assign port_levels_in = port_r;
  always @(posedge mclk) port_r <= port_r + 8'h25;
  // raise one line after dly edges, hold it for hold edges; dly gives a slow answer
  task raise(input int line, input int dly, input int hold);
    repeat (dly) @(posedge mclk);
    lines_r[line] <= 1'b1;
    repeat (hold) @(posedge mclk);
    lines_r[line] <= 1'b0;
  endtask : raise
endmodule : pmcd_partner
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the power control and clock divider unit
`include "pmcd_map.svh"
`default_nettype none
module tb
  import pmcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rstn, psel, penable, pwrite, pready, pslverr, irq, rst_pin, low_sup, pon;
  logic cpu_en, per_en, arr_en, osc, core_rst, rst0, baud2, fesel, ale, pss;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] port_in, port_out;
  pmcd_wake_t wake;
  int n_errors = 0;
  int tests_run = 0;
  int seed = 49;
  int ncpu, nper, narr;
  logic [32:0] expq[$];
  // short wake count keeps the run brief; expectations follow from 16
  pmcd_power_unit #(.WAKE_CYCLES(16)) pmcd_power_unit_i (
    .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_on_event(pon), .low_supply_detect(low_sup), .wake_pins(wake),
    .irq_pending(irq), .ext_reset_req(rst_pin), .port_levels_in(port_in),
    .port_levels_out(port_out), .cpu_clk_en(cpu_en), .periph_clk_en(per_en),
    .prog_counter_array_clk_en(arr_en), .osc_run(osc), .core_reset(core_rst),
    .core_restart_zero(rst0),
    .baud_double(baud2), .frame_error_select(fesel), .addr_latch_strobe(ale),
    .program_store_strobe(pss));
  pmcd_partner pmcd_partner_i (.mclk(mclk), .wake_pins(wake), .irq_pending(irq),
    .ext_reset_req(rst_pin), .low_supply_detect(low_sup), .power_on_event(pon),
    .port_levels_in(port_in));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen, then one idle edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_errors++;
      wrap_up();
    end
    @(posedge mclk);
  endtask : apb
  // a read notes its expected {slave error, data} before the transfer starts
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // completed reads take the oldest note off the queue
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (expq.size() == 0) chk({pslverr, prdata}, 33'h1ffffffff);
      else chk({pslverr, prdata}, expq.pop_front());
    end
  end
  // pulses of the three clock enables over a window
  task automatic count(input int len);
    {ncpu, nper, narr} = '0;
    repeat (len) begin
      @(posedge mclk);
      ncpu += int'(cpu_en === 1'b1);
      nper += int'(per_en === 1'b1);
      narr += int'(arr_en === 1'b1);
    end
  endtask : count
  initial begin
    logic [31:0] v;
    logic [7:0] f;
    logic [7:0] hold;
    int n;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rstn = 1'b0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rd(`PMCD_OFF_POWER_CTRL, 33'h10);
    rd(`PMCD_OFF_CORE_DIV, 33'h0);
    apb(1'b1, 12'h0c0, 32'hff);
    rd(12'h0c0, 33'h100000000);
    $display("test reset done");
    v = $random(seed);
    f = {v[7:6], 2'b00, v[3:2], 2'b00};
    apb(1'b1, `PMCD_OFF_POWER_CTRL, {24'h0, f});
    rd(`PMCD_OFF_POWER_CTRL, {25'h0, f});
    chk(baud2, f[7]);
    chk(fesel, f[6]);
    pmcd_partner_i.raise(10, 0, 2);
    apb(1'b1, `PMCD_OFF_POWER_CTRL, {24'h0, f | 8'h20});
    rd(`PMCD_OFF_POWER_CTRL, {25'h0, f | 8'h20});
    apb(1'b1, `PMCD_OFF_POWER_CTRL, {24'h0, f});
    rd(`PMCD_OFF_POWER_CTRL, {25'h0, f});
    pmcd_partner_i.raise(11, 1, 1);
    rd(`PMCD_OFF_POWER_CTRL, {25'h0, f | 8'h10});
    apb(1'b1, `PMCD_OFF_POWER_CTRL, {24'h0, f});
    $display("test flags done");
    for (int c = 0; c < 8; c++) begin
      v = $random(seed);
      apb(1'b1, `PMCD_OFF_CORE_DIV, {24'h0, v[7:3], 3'(c)});
      rd(`PMCD_OFF_CORE_DIV, {30'h0, 3'(c)});
      repeat (128) @(posedge mclk);
      count(256);
      chk(ncpu, 256 >> c);
    end
    $display("test divider done");
    // speed the core up from divide by 128 to divide by two before idle so 32 edges give 16 pulses
    apb(1'b1, `PMCD_OFF_CORE_DIV, 32'h1);
    apb(1'b1, `PMCD_OFF_CONFIG, 32'h1);
    apb(1'b1, `PMCD_OFF_POWER_CTRL, {24'h0, f | 8'h01});
    rd(`PMCD_OFF_STATUS, 33'h1);
    hold = port_out;
    count(32);
    chk(ncpu, 0);
    chk(nper, 16);
    chk(narr, 16);
    chk({port_out, ale, pss}, {hold, 2'b11});
    apb(1'b1, `PMCD_OFF_CONFIG, 32'h0);
    count(32);
    chk(narr, 0);
    pmcd_partner_i.raise(8, 3, 3);
    rd(`PMCD_OFF_STATUS, 33'h0);
    rd(`PMCD_OFF_POWER_CTRL, {25'h0, f});
    $display("test idle done");
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, `PMCD_OFF_POWER_CTRL, {24'h0, f | (c == 0 ? 8'h03 : 8'h02)});
      rd(`PMCD_OFF_STATUS, 33'h2);
      chk(osc, 1'b0);
      pmcd_partner_i.raise(c, c, 2);
      rd(`PMCD_OFF_STATUS, 33'h3);
      repeat (20) @(posedge mclk);
      rd(`PMCD_OFF_STATUS, 33'h0);
      rd(`PMCD_OFF_POWER_CTRL, {25'h0, f});
    end
    $display("test power-down done");
    for (int m = 1; m <= 2; m++) begin
      apb(1'b1, `PMCD_OFF_POWER_CTRL, {24'h0, f | 8'(m)});
      n = 0;
      fork
        pmcd_partner_i.raise(9, 0, 30);
        do begin
          @(posedge mclk);
          n++;
        end while (core_rst !== 1'b1 && n < 60);
      join_any
      chk(rst0, 1'b1);
      chk(n >= 24 && n <= 26, 1'b1);
      wait fork;
      rd(`PMCD_OFF_STATUS, 33'h0);
    end
    $display("test reset pin done");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
